// file: src/hfsi_cfg.svh
`ifndef HFSI_CFG_SVH
`define HFSI_CFG_SVH

`define HFSI_CHANNELS           4
`define HFSI_FIFO_DEPTH         64
`define HFSI_CH_LSB             11
`define HFSI_IDX_RX_FIFO_CTRL   9'h087
`define HFSI_IDX_RX_LATCHED     9'h094
`define HFSI_IDX_RX_MASK        9'h0A4
`define HFSI_IDX_RX_REALTIME    9'h0B4
`define HFSI_IDX_RX_BYTES_AVAIL 9'h0B5
`define HFSI_IDX_RX_FIFO_DATA   9'h0B6
`define HFSI_IDX_TX_FIFO_CTRL   9'h187
`define HFSI_IDX_TX_LATCHED     9'h191
`define HFSI_IDX_TX_MASK        9'h1A1
`define HFSI_IDX_TX_REALTIME    9'h1B1
`define HFSI_IDX_TX_BUF_AVAIL   9'h1B3
`define HFSI_IDX_TX_FIFO_DATA   9'h1B4
`define HFSI_RX_EMPTY_BIT       0
`define HFSI_RX_HWM_BIT         1
`define HFSI_RX_EOP_BIT         0
`define HFSI_RX_OVR_BIT         5
`define HFSI_TX_EMPTY_BIT       0
`define HFSI_TX_LWM_BIT         1
`define HFSI_RST_RX_FIFO_CTRL   8'h30
`define HFSI_RST_TX_FIFO_CTRL   8'h10
`define HFSI_RST_MASK           8'h00

`endif

// file: src/hfsi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "hfsi_cfg.svh"

module hfsi_fifo import hfsi_pkg::*; #(
  parameter int DEPTH = `HFSI_FIFO_DEPTH,
  parameter int W     = 9,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  input  wire logic          pop,
  input  wire logic          flush,
  output logic      [W-1:0]  head_data,
  output logic      [CW-1:0] count,
  output logic               full,
  output logic               empty,
  output logic      [CW-1:0] lead_count,
  output logic               lead_open
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           rd;
    logic [PW-1:0]           wr;
    logic [CW-1:0]           cnt;
  } hfsi_fifo_state_type;

  hfsi_fifo_state_type st_reg;
  hfsi_fifo_state_type st_next;
  logic                push_ok;
  logic                pop_ok;
  logic                found;
  logic [PW-1:0]       idx;

  assign full      = (st_reg.cnt == CW'(DEPTH));
  assign empty     = (st_reg.cnt == '0);
  assign count     = st_reg.cnt;
  assign head_data = st_reg.mem[st_reg.rd];
  assign push_ok   = push & ~full;
  assign pop_ok    = pop & ~empty;

  // Storage is written only when not full, so nothing is overwritten
  always_comb begin
    st_next = st_reg;
    if (flush) begin
      st_next.rd  = '0;
      st_next.wr  = '0;
      st_next.cnt = '0;
    end else begin
      if (push_ok) begin
        st_next.mem[st_reg.wr] = push_data;
        st_next.wr = st_reg.wr + PW'(1);
      end
      if (pop_ok) begin
        st_next.rd = st_reg.rd + PW'(1);
      end
      st_next.cnt = st_reg.cnt + CW'(push_ok) - CW'(pop_ok);
    end
  end

  // Bytes from head up to the first end-of-message mark
  always_comb begin
    found      = 1'b0;
    idx        = '0;
    lead_count = st_reg.cnt;
    for (int i = 0; i < DEPTH; i++) begin
      idx = st_reg.rd + PW'(i);
      if (!found && CW'(i) < st_reg.cnt && st_reg.mem[idx][W-1]) begin
        found      = 1'b1;
        lead_count = CW'(i + 1);
      end
    end
    lead_open = ~found & ~empty;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : hfsi_fifo
`default_nettype wire

// file: src/hfsi_latch.sv
`timescale 1ns/1ps
`default_nettype none

module hfsi_latch import hfsi_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] set,
  input  wire logic         clr_wr,
  input  wire logic [W-1:0] clr_data,
  input  wire logic         rd_ack,
  input  wire logic [W-1:0] mask,
  output logic      [W-1:0] status,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] acked;
    logic         irq;
  } hfsi_latch_state_type;

  hfsi_latch_state_type st_reg;
  hfsi_latch_state_type st_next;

  assign status = st_reg.status;
  assign irq    = st_reg.irq;

  // A new event wins over a clear in the same cycle
  always_comb begin
    st_next = st_reg;
    st_next.status = st_reg.status;
    if (clr_wr) begin
      st_next.status = st_reg.status & ~clr_data;
    end
    st_next.status = st_next.status | set;
    st_next.acked = st_reg.acked;
    if (rd_ack) begin
      st_next.acked = st_reg.acked | st_reg.status;
    end
    st_next.acked = st_next.acked & ~set & st_next.status;
    st_next.irq = |(st_next.status & mask & ~st_next.acked);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : hfsi_latch
`default_nettype wire

// file: src/hfsi_pkg.sv
package hfsi_pkg;

  typedef enum logic [3:0] {
    HFSI_SEL_NONE        = 4'h0,
    HFSI_SEL_RX_CTRL     = 4'h1,
    HFSI_SEL_RX_LATCHED  = 4'h2,
    HFSI_SEL_RX_MASK     = 4'h3,
    HFSI_SEL_RX_REALTIME = 4'h4,
    HFSI_SEL_RX_AVAIL    = 4'h5,
    HFSI_SEL_RX_DATA     = 4'h6,
    HFSI_SEL_TX_CTRL     = 4'h7,
    HFSI_SEL_TX_LATCHED  = 4'h8,
    HFSI_SEL_TX_MASK     = 4'h9,
    HFSI_SEL_TX_REALTIME = 4'hA,
    HFSI_SEL_TX_AVAIL    = 4'hB,
    HFSI_SEL_TX_DATA     = 4'hC
  } hfsi_reg_sel_type;

endpackage : hfsi_pkg

// file: src/hfsi_top.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "hfsi_cfg.svh"

module hfsi_top import hfsi_pkg::*; #(
  parameter int CH    = `HFSI_CHANNELS,
  parameter int DEPTH = `HFSI_FIFO_DEPTH
) (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [12:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 interrupt_out_n,
  input  wire logic [CH-1:0]   rx_byte_valid,
  input  wire logic [CH*8-1:0] rx_byte_data,
  input  wire logic [CH-1:0]   rx_byte_last,
  input  wire logic [CH-1:0]   tx_byte_req,
  output logic      [CH*8-1:0] tx_byte_data,
  output logic      [CH-1:0]   tx_byte_valid
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  typedef struct packed {
    logic [CH-1:0][7:0] rx_ctrl;
    logic [CH-1:0][7:0] tx_ctrl;
    logic [CH-1:0][7:0] rx_mask;
    logic [CH-1:0][7:0] tx_mask;
    logic [CH-1:0]      rx_hwm_q;
    logic [CH-1:0]      tx_lwm_q;
    logic [CH-1:0]      tx_empty_q;
    logic [CH-1:0]      rx_skip;
    logic [CH-1:0]      rx_pkt_ovr;
    logic [CH-1:0][7:0] tx_data;
    logic [CH-1:0]      tx_valid;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               irq_n;
  } hfsi_top_state_type;

  hfsi_top_state_type st_reg;
  hfsi_top_state_type st_next;

  logic [CH-1:0]          rx_push, rx_pop, rx_flush, rx_full, rx_empty;
  logic [CH-1:0]          rx_open, tx_push, tx_pop, tx_full, tx_empty;
  logic [CH-1:0]          rx_clr, tx_clr, rx_ack, tx_ack, rx_irq, tx_irq;
  logic [CH-1:0]          rx_hwm, tx_lwm;
  logic [CH-1:0][8:0]     rx_head;
  logic [CH-1:0][7:0]     tx_head, rx_set, tx_set, rx_latched, tx_latched;
  logic [CH-1:0][7:0]     rx_rt, tx_rt, rx_avail, tx_avail;
  logic [CH-1:0][CW-1:0]  rx_cnt, rx_lead, tx_cnt;
  hfsi_reg_sel_type       sel;
  logic [1:0]             ch;
  logic [8:0]             loc;
  logic                   setup;
  logic                   wr_take;

  assign prdata          = st_reg.prdata;
  assign pready          = st_reg.pready;
  assign pslverr         = st_reg.pslverr;
  assign interrupt_out_n = st_reg.irq_n;
  assign tx_byte_data    = st_reg.tx_data;
  assign tx_byte_valid   = st_reg.tx_valid;

  assign ch      = paddr[`HFSI_CH_LSB+1:`HFSI_CH_LSB];
  assign loc     = paddr[`HFSI_CH_LSB-1:2];
  assign setup   = psel & ~penable;
  assign wr_take = psel & penable & st_reg.pready & pwrite;

  // Word index times four is the byte address
  always_comb begin
    if (loc == `HFSI_IDX_RX_FIFO_CTRL) begin
      sel = HFSI_SEL_RX_CTRL;
    end else if (loc == `HFSI_IDX_RX_LATCHED) begin
      sel = HFSI_SEL_RX_LATCHED;
    end else if (loc == `HFSI_IDX_RX_MASK) begin
      sel = HFSI_SEL_RX_MASK;
    end else if (loc == `HFSI_IDX_RX_REALTIME) begin
      sel = HFSI_SEL_RX_REALTIME;
    end else if (loc == `HFSI_IDX_RX_BYTES_AVAIL) begin
      sel = HFSI_SEL_RX_AVAIL;
    end else if (loc == `HFSI_IDX_RX_FIFO_DATA) begin
      sel = HFSI_SEL_RX_DATA;
    end else if (loc == `HFSI_IDX_TX_FIFO_CTRL) begin
      sel = HFSI_SEL_TX_CTRL;
    end else if (loc == `HFSI_IDX_TX_LATCHED) begin
      sel = HFSI_SEL_TX_LATCHED;
    end else if (loc == `HFSI_IDX_TX_MASK) begin
      sel = HFSI_SEL_TX_MASK;
    end else if (loc == `HFSI_IDX_TX_REALTIME) begin
      sel = HFSI_SEL_TX_REALTIME;
    end else if (loc == `HFSI_IDX_TX_BUF_AVAIL) begin
      sel = HFSI_SEL_TX_AVAIL;
    end else if (loc == `HFSI_IDX_TX_FIFO_DATA) begin
      sel = HFSI_SEL_TX_DATA;
    end else begin
      sel = HFSI_SEL_NONE;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      hfsi_fifo #(.DEPTH(DEPTH), .W(9)) u_rx_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .push      (rx_push[g]),
        .push_data ({rx_byte_last[g], rx_byte_data[g*8 +: 8]}),
        .pop       (rx_pop[g]),
        .flush     (rx_flush[g]),
        .head_data (rx_head[g]),
        .count     (rx_cnt[g]),
        .full      (rx_full[g]),
        .empty     (rx_empty[g]),
        .lead_count(rx_lead[g]),
        .lead_open (rx_open[g])
      );
      hfsi_fifo #(.DEPTH(DEPTH), .W(8)) u_tx_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .push      (tx_push[g]),
        .push_data (pwdata[7:0]),
        .pop       (tx_pop[g]),
        .flush     (1'b0),
        .head_data (tx_head[g]),
        .count     (tx_cnt[g]),
        .full      (tx_full[g]),
        .empty     (tx_empty[g]),
        .lead_count(),
        .lead_open ()
      );
      hfsi_latch #(.W(8)) u_rx_latch (
        .clk     (clk),
        .arst_n  (arst_n),
        .set     (rx_set[g]),
        .clr_wr  (rx_clr[g]),
        .clr_data(pwdata[7:0]),
        .rd_ack  (rx_ack[g]),
        .mask    (st_reg.rx_mask[g]),
        .status  (rx_latched[g]),
        .irq     (rx_irq[g])
      );
      hfsi_latch #(.W(8)) u_tx_latch (
        .clk     (clk),
        .arst_n  (arst_n),
        .set     (tx_set[g]),
        .clr_wr  (tx_clr[g]),
        .clr_data(pwdata[7:0]),
        .rd_ack  (tx_ack[g]),
        .mask    (st_reg.tx_mask[g]),
        .status  (tx_latched[g]),
        .irq     (tx_irq[g])
      );
    end
  endgenerate

  always_comb begin
    st_next  = st_reg;
    rx_push  = '0;
    rx_pop   = '0;
    rx_flush = '0;
    tx_push  = '0;
    tx_pop   = '0;
    rx_set   = '0;
    tx_set   = '0;
    rx_clr   = '0;
    tx_clr   = '0;
    rx_ack   = '0;
    tx_ack   = '0;
    rx_hwm   = '0;
    tx_lwm   = '0;
    rx_rt    = '0;
    tx_rt    = '0;
    rx_avail = '0;
    tx_avail = '0;

    for (int c = 0; c < CH; c++) begin
      rx_hwm[c] = rx_cnt[c] > st_reg.rx_ctrl[c][CW-1:0];
      tx_lwm[c] = tx_cnt[c] < st_reg.tx_ctrl[c][CW-1:0];
      rx_rt[c][`HFSI_RX_EMPTY_BIT] = rx_empty[c];
      rx_rt[c][`HFSI_RX_HWM_BIT]   = rx_hwm[c];
      rx_rt[c][`HFSI_RX_OVR_BIT]   = st_reg.rx_pkt_ovr[c];
      tx_rt[c][`HFSI_TX_EMPTY_BIT] = tx_empty[c];
      tx_rt[c][`HFSI_TX_LWM_BIT]   = tx_lwm[c];
      rx_avail[c] = {rx_open[c], rx_lead[c]};
      tx_avail[c] = {1'b0, DEPTH_C - tx_cnt[c]};

      // Rest of an overrun packet is dropped until its last byte
      if (rx_byte_valid[c]) begin
        if (st_reg.rx_skip[c]) begin
          st_next.rx_skip[c] = ~rx_byte_last[c];
        end else if (rx_full[c]) begin
          rx_flush[c] = 1'b1;
          rx_set[c][`HFSI_RX_OVR_BIT] = 1'b1;
          st_next.rx_pkt_ovr[c] = 1'b1;
          st_next.rx_skip[c] = ~rx_byte_last[c];
        end else begin
          rx_push[c] = 1'b1;
          if (rx_byte_last[c]) begin
            rx_set[c][`HFSI_RX_EOP_BIT] = 1'b1;
            st_next.rx_pkt_ovr[c] = 1'b0;
          end
        end
      end
      rx_set[c][`HFSI_RX_HWM_BIT] = rx_hwm[c] & ~st_reg.rx_hwm_q[c];
      tx_set[c][`HFSI_TX_LWM_BIT] = tx_lwm[c] & ~st_reg.tx_lwm_q[c];
      tx_set[c][`HFSI_TX_EMPTY_BIT] = tx_empty[c] & ~st_reg.tx_empty_q[c];
      st_next.rx_hwm_q[c]   = rx_hwm[c];
      st_next.tx_lwm_q[c]   = tx_lwm[c];
      st_next.tx_empty_q[c] = tx_empty[c];

      tx_pop[c] = tx_byte_req[c] & ~tx_empty[c];
      st_next.tx_valid[c] = tx_pop[c];
      if (tx_pop[c]) begin
        st_next.tx_data[c] = tx_head[c];
      end
    end

    // Read data is sampled once in setup, so it cannot move mid-access
    st_next.pready  = setup;
    st_next.pslverr = setup & (sel == HFSI_SEL_NONE);
    if (setup && !pwrite) begin
      st_next.prdata = '0;
      case (sel)
        HFSI_SEL_RX_CTRL: begin
          st_next.prdata[7:0] = st_reg.rx_ctrl[ch];
        end
        HFSI_SEL_RX_LATCHED: begin
          st_next.prdata[7:0] = rx_latched[ch];
          rx_ack[ch] = 1'b1;
        end
        HFSI_SEL_RX_MASK: begin
          st_next.prdata[7:0] = st_reg.rx_mask[ch];
        end
        HFSI_SEL_RX_REALTIME: begin
          st_next.prdata[7:0] = rx_rt[ch];
        end
        HFSI_SEL_RX_AVAIL: begin
          st_next.prdata[7:0] = rx_avail[ch];
        end
        HFSI_SEL_RX_DATA: begin
          st_next.prdata[7:0] = rx_empty[ch] ? 8'h00 : rx_head[ch][7:0];
          rx_pop[ch] = ~rx_empty[ch] & ~rx_flush[ch];
        end
        HFSI_SEL_TX_CTRL: begin
          st_next.prdata[7:0] = st_reg.tx_ctrl[ch];
        end
        HFSI_SEL_TX_LATCHED: begin
          st_next.prdata[7:0] = tx_latched[ch];
          tx_ack[ch] = 1'b1;
        end
        HFSI_SEL_TX_MASK: begin
          st_next.prdata[7:0] = st_reg.tx_mask[ch];
        end
        HFSI_SEL_TX_REALTIME: begin
          st_next.prdata[7:0] = tx_rt[ch];
        end
        HFSI_SEL_TX_AVAIL: begin
          st_next.prdata[7:0] = tx_avail[ch];
        end
        default: begin
          st_next.prdata = '0;
        end
      endcase
    end

    if (wr_take) begin
      if (sel == HFSI_SEL_RX_CTRL) begin
        st_next.rx_ctrl[ch] = pwdata[7:0];
      end else if (sel == HFSI_SEL_TX_CTRL) begin
        st_next.tx_ctrl[ch] = pwdata[7:0];
      end else if (sel == HFSI_SEL_RX_MASK) begin
        st_next.rx_mask[ch] = pwdata[7:0];
      end else if (sel == HFSI_SEL_TX_MASK) begin
        st_next.tx_mask[ch] = pwdata[7:0];
      end else if (sel == HFSI_SEL_RX_LATCHED) begin
        rx_clr[ch] = 1'b1;
      end else if (sel == HFSI_SEL_TX_LATCHED) begin
        tx_clr[ch] = 1'b1;
      end else if (sel == HFSI_SEL_TX_DATA) begin
        tx_push[ch] = 1'b1;
      end
    end

    st_next.irq_n = ~(|rx_irq | |tx_irq);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.rx_ctrl  <= {CH{`HFSI_RST_RX_FIFO_CTRL}};
      st_reg.tx_ctrl  <= {CH{`HFSI_RST_TX_FIFO_CTRL}};
      st_reg.rx_mask  <= {CH{`HFSI_RST_MASK}};
      st_reg.tx_mask  <= {CH{`HFSI_RST_MASK}};
      st_reg.irq_n    <= 1'b1;
      st_reg.tx_empty_q <= '1;
      // Empty FIFO starts below the mark: no false event after reset
      st_reg.tx_lwm_q   <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : hfsi_top
`default_nettype wire

// file: verif/hfsi_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "hfsi_cfg.svh"

module hfsi_checker #(
  parameter int CH    = 4,
  parameter int DEPTH = 64
) (
  input wire logic          clk,
  input wire logic          arst_n,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [12:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          interrupt_out_n,
  input wire logic [CH-1:0] tx_byte_req,
  input wire logic [CH-1:0] tx_byte_valid
);
  logic [8:0] idx;
  logic       rd_done;
  logic       wr_done;
  logic       mapped;
  logic [7:0] mask_nz_reg;
  logic [6:0] wm0_reg;

  assign idx     = paddr[10:2];
  assign rd_done = psel && penable && pready && !pwrite;
  assign wr_done = psel && penable && pready && pwrite;
  assign mapped  = idx inside {`HFSI_IDX_RX_FIFO_CTRL, `HFSI_IDX_RX_LATCHED,
    `HFSI_IDX_RX_MASK, `HFSI_IDX_RX_REALTIME, `HFSI_IDX_RX_BYTES_AVAIL,
    `HFSI_IDX_RX_FIFO_DATA, `HFSI_IDX_TX_FIFO_CTRL, `HFSI_IDX_TX_LATCHED,
    `HFSI_IDX_TX_MASK, `HFSI_IDX_TX_REALTIME, `HFSI_IDX_TX_BUF_AVAIL,
    `HFSI_IDX_TX_FIFO_DATA};

  // Any nonzero mask byte may legally let an event through
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_nz_reg <= 8'h00;
      wm0_reg     <= 7'h30;
    end else if (wr_done) begin
      if (idx == `HFSI_IDX_RX_MASK)
        mask_nz_reg[{1'b0, paddr[12:11]}] <= |pwdata[7:0];
      if (idx == `HFSI_IDX_TX_MASK)
        mask_nz_reg[{1'b1, paddr[12:11]}] <= |pwdata[7:0];
      if (idx == `HFSI_IDX_RX_FIFO_CTRL && paddr[12:11] == 2'h0)
        wm0_reg <= pwdata[6:0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pulse;
    pready ##1 !pready;
  endsequence

  chk_ready_pulse: assert property (s_setup |=> s_pulse)
    else $error("pready not a single cycle after setup");
  chk_read_stable: assert property (rd_done |=> $stable(prdata))
    else $error("read data changed right after access");
  chk_avail_range: assert property (rd_done &&
    idx == `HFSI_IDX_RX_BYTES_AVAIL |-> prdata[6:0] <= DEPTH &&
    prdata[31:8] == 24'h0)
    else $error("rx byte count out of range");
  chk_free_range: assert property (rd_done &&
    idx == `HFSI_IDX_TX_BUF_AVAIL |-> prdata <= DEPTH)
    else $error("tx free count above depth");
  chk_err_decode: assert property (psel && penable && pready
    |-> pslverr == !mapped && (mapped || pwrite || prdata == 32'h0))
    else $error("error response does not match decode");
  chk_mask_gate: assert property ((mask_nz_reg == 8'h00)[*3]
    |-> interrupt_out_n)
    else $error("interrupt with all masks clear");
  chk_wm_readback: assert property (rd_done &&
    idx == `HFSI_IDX_RX_FIFO_CTRL && paddr[12:11] == 2'h0
    |-> prdata[6:0] == wm0_reg)
    else $error("watermark readback mismatch");
  chk_tx_cause: assert property (
    (tx_byte_valid & ~$past(tx_byte_req)) == '0)
    else $error("tx byte valid without request");
endmodule : hfsi_checker

bind hfsi_top hfsi_checker #(.CH(CH), .DEPTH(DEPTH)) u_chk (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .interrupt_out_n(interrupt_out_n),
  .tx_byte_req(tx_byte_req), .tx_byte_valid(tx_byte_valid)
);
`default_nettype wire

// file: verif/hfsi_host.sv
`timescale 1ns/1ps
`default_nettype none

module hfsi_host (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [12:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 13'h0000;
    pwdata  = 32'h0000_0000;
  end

  // Request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [12:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : hfsi_host
`default_nettype wire

// file: verif/hfsi_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hfsi_cfg.svh"

module hfsi_tb_top;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        interrupt_out_n;
  logic [12:0] paddr;
  logic [31:0] pwdata, prdata, rx_byte_data, tx_byte_data, q;
  logic [3:0]  rx_byte_valid, rx_byte_last, tx_byte_req, tx_byte_valid;
  logic [8:0]  rxq[4][$];
  logic [7:0]  txq[4][$];
  logic [7:0]  rlat[4] = '{default: 8'h00};
  bit          drop[4] = '{default: 0};
  bit          ovr[4] = '{default: 0};
  int          hwm[4] = '{default: 48};
  int          errors = 0;
  int          check_count = 0;
  integer      seed = 32'h1d8f;

  hfsi_top uut (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .interrupt_out_n(interrupt_out_n),
    .rx_byte_valid(rx_byte_valid), .rx_byte_data(rx_byte_data),
    .rx_byte_last(rx_byte_last), .tx_byte_req(tx_byte_req),
    .tx_byte_data(tx_byte_data), .tx_byte_valid(tx_byte_valid));
  hfsi_host host (
    .clk(clk), .prdata(prdata), .pready(pready), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wr(int c, logic [8:0] i, logic [7:0] d);
    host.xfer(1'b1, {c[1:0], i, 2'b00}, {24'h0, d}, q);
  endtask : wr

  task automatic rd(int c, logic [8:0] i, logic [31:0] e);
    host.xfer(1'b0, {c[1:0], i, 2'b00}, 32'h0, q);
    chk_word(q, e);
  endtask : rd

  task automatic irq_chk(logic e);
    repeat (3) @(posedge clk);
    chk_pin(interrupt_out_n, e);
  endtask : irq_chk

  // Count up to the first message end, else whole fill marked open
  function automatic logic [31:0] avail(int c);
    for (int k = 0; k < rxq[c].size(); k++)
      if (rxq[c][k][8]) return 32'(k + 1);
    return rxq[c].size() > 0 ? 32'(128 + rxq[c].size()) : 32'h0;
  endfunction : avail

  function automatic logic [31:0] rt_rx(int c);
    return {26'h0, ovr[c], 3'h0, rxq[c].size() > hwm[c], rxq[c].size() == 0};
  endfunction : rt_rx

  task automatic send(int c, int n, bit fin);
    logic [7:0] b;
    bit         l;
    int         s;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      l = fin && i == n - 1;
      s = rxq[c].size();
      @(posedge clk);
      rx_byte_valid[c]       <= 1'b1;
      rx_byte_data[c*8 +: 8] <= b;
      rx_byte_last[c]        <= l;
      if (drop[c]) drop[c] = !l;
      else if (s == 64) begin
        rxq[c].delete();
        rlat[c][5] = 1'b1;
        ovr[c] = 1'b1;
        drop[c] = !l;
      end else begin
        rxq[c].push_back({l, b});
        if (s == hwm[c]) rlat[c][1] = 1'b1;
        if (l) rlat[c][0] = 1'b1;
        if (l) ovr[c] = 1'b0;
      end
    end
    @(posedge clk);
    rx_byte_valid[c] <= 1'b0;
  endtask : send

  // Reading an empty FIFO must not pop, so expect zero then
  task automatic pop_chk(int c);
    logic [8:0] e;
    e = rxq[c].size() > 0 ? rxq[c].pop_front() : 9'h0;
    rd(c, `HFSI_IDX_RX_FIFO_DATA, {24'h0, e[7:0]});
  endtask : pop_chk

  initial begin
    #(20 * 20000);
    errors++;
    end_of_test();
  end

  initial begin
    logic [7:0] b;
    arst_n        = 1'b0;
    rx_byte_valid = 4'h0;
    rx_byte_data  = 32'h0;
    rx_byte_last  = 4'h0;
    tx_byte_req   = 4'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(c, `HFSI_IDX_RX_FIFO_CTRL, 32'h30);
      rd(c, `HFSI_IDX_TX_FIFO_CTRL, 32'h10);
      rd(c, `HFSI_IDX_RX_MASK, 32'h0);
      rd(c, `HFSI_IDX_RX_LATCHED, 32'h0);
      rd(c, `HFSI_IDX_TX_LATCHED, 32'h0);
      rd(c, `HFSI_IDX_RX_REALTIME, rt_rx(c));
      rd(c, `HFSI_IDX_TX_REALTIME, 32'h3);
      rd(c, `HFSI_IDX_TX_BUF_AVAIL, 32'h40);
      rd(c, `HFSI_IDX_RX_BYTES_AVAIL, avail(c));
    end
    rd(0, 9'h000, 32'h0);
    wr(0, `HFSI_IDX_RX_FIFO_CTRL, 8'h04);
    hwm[0] = 4;
    rd(0, `HFSI_IDX_RX_FIFO_CTRL, 32'h04);
    rd(1, `HFSI_IDX_RX_FIFO_CTRL, 32'h30);
    send(0, 4, 1'b0);
    rd(0, `HFSI_IDX_RX_REALTIME, rt_rx(0));
    rd(0, `HFSI_IDX_RX_BYTES_AVAIL, avail(0));
    send(0, 1, 1'b0);
    rd(0, `HFSI_IDX_RX_REALTIME, rt_rx(0));
    send(0, 2, 1'b1);
    rd(0, `HFSI_IDX_RX_BYTES_AVAIL, avail(0));
    repeat (8) pop_chk(0);
    rd(0, `HFSI_IDX_RX_LATCHED, {24'h0, rlat[0]});
    send(1, 3, 1'b1);
    irq_chk(1'b1);
    wr(1, `HFSI_IDX_RX_MASK, 8'h01);
    irq_chk(1'b0);
    rd(1, `HFSI_IDX_RX_LATCHED, 32'h1);
    irq_chk(1'b1);
    wr(1, `HFSI_IDX_RX_LATCHED, 8'hFE);
    rd(1, `HFSI_IDX_RX_LATCHED, 32'h1);
    send(1, 1, 1'b1);
    irq_chk(1'b0);
    wr(1, `HFSI_IDX_RX_LATCHED, 8'h01);
    irq_chk(1'b1);
    rd(1, `HFSI_IDX_RX_LATCHED, 32'h0);
    wr(1, `HFSI_IDX_RX_MASK, 8'h00);
    send(2, 65, 1'b0);
    rd(2, `HFSI_IDX_RX_BYTES_AVAIL, avail(2));
    rd(2, `HFSI_IDX_RX_REALTIME, rt_rx(2));
    rd(2, `HFSI_IDX_RX_LATCHED, {24'h0, rlat[2]});
    send(2, 2, 1'b1);
    send(2, 3, 1'b1);
    rd(2, `HFSI_IDX_RX_BYTES_AVAIL, avail(2));
    rd(2, `HFSI_IDX_RX_REALTIME, rt_rx(2));
    wr(3, `HFSI_IDX_TX_LATCHED, 8'hFF);
    for (int i = 0; i < 65; i++) begin
      b = 8'($random(seed));
      wr(3, `HFSI_IDX_TX_FIFO_DATA, b);
      if (txq[3].size() < 64) txq[3].push_back(b);
    end
    rd(3, `HFSI_IDX_TX_BUF_AVAIL, 32'h0);
    rd(3, `HFSI_IDX_TX_REALTIME, 32'h0);
    wr(3, `HFSI_IDX_TX_MASK, 8'h01);
    // Requests back to back; last one finds the FIFO empty
    for (int i = 0; i < 67; i++) begin
      @(posedge clk);
      if (i >= 2) chk_pin(tx_byte_valid[3], i < 66);
      if (i >= 2 && i < 66)
        chk_word(tx_byte_data[31:24], txq[3].pop_front());
      tx_byte_req[3] <= i < 65;
    end
    rd(3, `HFSI_IDX_TX_REALTIME, 32'h3);
    rd(3, `HFSI_IDX_TX_BUF_AVAIL, 32'h40);
    irq_chk(1'b0);
    rd(3, `HFSI_IDX_TX_LATCHED, 32'h3);
    irq_chk(1'b1);
    wr(3, `HFSI_IDX_TX_LATCHED, 8'h03);
    rd(3, `HFSI_IDX_TX_LATCHED, 32'h0);
    wr(2, `HFSI_IDX_TX_FIFO_CTRL, 8'h00);
    rd(2, `HFSI_IDX_TX_FIFO_CTRL, 32'h0);
    rd(2, `HFSI_IDX_TX_REALTIME, 32'h1);
    end_of_test();
  end
endmodule : hfsi_tb_top
`default_nettype wire
